// >>> hdl/rss_regs.svh
// Constants for the rotate, skip and subtract execution unit
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_DATA_W      8
`define RSS_PC_W        14
`define RSS_STACK_DEPTH 16
`define RSS_SP_W        5
`define RSS_ACC_RESET   8'h00
`define RSS_PC_RESET    14'h0000
`define RSS_IRQ_VECTOR  14'h0004
`define RSS_BYTE_ONES   8'hFF
`define RSS_BYTE_ZERO   8'h00
`define RSS_PC_STEP     14'h0001
`define RSS_PC_SKIP     14'h0002
`define RSS_ONE         8'h01

`endif

// >>> hdl/rss_pkg.sv
// Types shared by the rotate, skip and subtract execution unit
`default_nettype none
`include "rss_regs.svh"

package rss_pkg;

  typedef enum logic [4:0] {
    RSS_NOP,
    RSS_OR_TO_MEMORY,
    RSS_RET,
    RSS_RET_LOAD,
    RSS_IRQ_RETURN,
    RSS_ROT_LEFT,
    RSS_ROT_LEFT_A,
    RSS_ROT_RIGHT,
    RSS_ROT_RIGHT_A,
    RSS_ROTATE_LEFT_THRU_BORROW_BIT,
    RSS_ROTATE_LEFT_THRU_BORROW_BIT_A,
    RSS_ROTATE_RIGHT_THRU_BORROW_BIT,
    RSS_ROTATE_RIGHT_THRU_BORROW_BIT_A,
    RSS_SUBTRACT_WITH_BORROW,
    RSS_SUBTRACT_WITH_BORROW_IMM,
    RSS_SUBTRACT_WITH_BORROW_TO_MEM,
    RSS_DECREMENT_SKIP_IF_NULL,
    RSS_DECREMENT_SKIP_IF_NULL_A,
    RSS_INCREMENT_SKIP_IF_NULL,
    RSS_INCREMENT_SKIP_IF_NULL_A,
    RSS_SET_BYTE,
    RSS_SET_BIT,
    RSS_SKIP_IF_BIT_NONNULL,
    RSS_SKIP_IF_NONNULL,
    RSS_SUB_MEM,
    RSS_CALL
  } rss_op_type;

  typedef struct packed {
    logic                    valid;
    rss_op_type              op;
    logic [`RSS_DATA_W-1:0]  mem_data;
    logic [`RSS_DATA_W-1:0]  imm;
    logic [2:0]              bit_sel;
    logic [`RSS_PC_W-1:0]    target;
  } rss_instr_type;

  typedef struct packed {
    logic carry_flag;
    logic zero_flag;
    logic half_borrow_flag;
    logic signed_wrap_flag;
    logic signed_borrow_flag;
    logic chained_null_flag;
  } rss_flags_type;

  typedef enum logic {
    RSS_EXEC,
    RSS_SLOT
  } rss_state_type;

endpackage : rss_pkg

`default_nettype wire

// >>> hdl/rss_sub_unit.sv
// Subtract datapath with borrow term and full flag generation
`default_nettype none
`include "rss_regs.svh"

module rss_sub_unit
  import rss_pkg::*;
(
  input  wire logic [`RSS_DATA_W-1:0] minuend_in,     // Working register value
  input  wire logic [`RSS_DATA_W-1:0] subtrahend_in,  // Memory byte or literal
  input  wire rss_flags_type          flags_in,       // Flags before the operation
  input  wire logic                   use_borrow_in,  // Include inverted carry term
  output logic      [`RSS_DATA_W-1:0] diff_out,       // Difference
  output rss_flags_type               flags_out       // Flags after the operation
);

  wire logic       borrow_in = use_borrow_in & ~flags_in.carry_flag;
  wire logic [8:0] diff9 = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {8'h00, borrow_in};
  wire logic [4:0] low5  = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]} - {4'h0, borrow_in};
  wire logic       is_zero = (diff9[7:0] == `RSS_BYTE_ZERO);
  wire logic       wrap = (minuend_in[7] ^ subtrahend_in[7]) & (diff9[7] ^ minuend_in[7]);
  // Chained zero only accumulates across the borrow form
  wire logic       chain = use_borrow_in ? (is_zero & flags_in.chained_null_flag) : is_zero;

  assign diff_out = diff9[7:0];
  // carry means no borrow; one driver for the whole flag word, carry first
  assign flags_out = {~diff9[8], is_zero, ~low5[4], wrap, wrap ^ diff9[7], chain};

endmodule : rss_sub_unit

`default_nettype wire

// >>> hdl/rss_stack.sv
// Hardware return-address stack
`default_nettype none
`include "rss_regs.svh"

module rss_stack
  import rss_pkg::*;
(
  input  wire logic                  clk_in,    // System clock
  input  wire logic                  reset_in,  // Asynchronous reset, active high
  input  wire logic                  push_in,   // Push one address
  input  wire logic                  pop_in,    // Pop one address
  input  wire logic [`RSS_PC_W-1:0]  data_in,   // Address to push
  output logic      [`RSS_PC_W-1:0]  top_out    // Address on top of stack
);

  logic [`RSS_PC_W-1:0] mem [`RSS_STACK_DEPTH];
  logic [`RSS_SP_W-2:0] sp;

  // Pointer wraps on overflow, so the deepest entry is silently overwritten
  wire logic [`RSS_SP_W-2:0] top_idx = sp - 4'h1;
  assign top_out = mem[top_idx];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sp <= '0;
    end else if (push_in) begin
      sp <= sp + 4'h1;
    end else if (pop_in) begin
      sp <= top_idx;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_in) begin
      mem[sp] <= data_in;
    end
  end

endmodule : rss_stack

`default_nettype wire

// >>> hdl/rss_exec_unit.sv
// Execution unit for or-to-memory, returns, rotates, subtracts, skips and set
//
// Overview of operation
// - Or-to-memory writes working register OR data byte back to memory.
// - Return pops program counter from stack; flags stay untouched.
// - Return-with-value pops program counter and loads immediate into working register.
// - Interrupt return with no interrupt pending pops program counter and sets the master interrupt gate.
// - Pending interrupt at interrupt return is serviced before the main program resumes.
// - Plain rotate left moves bit 7 into bit 0, no flags.
// - Plain rotate right moves bit 0 into bit 7, no flags.
// - Rotate left through carry: bit 7 to carry, carry to bit 0.
// - Rotate right through carry: bit 0 to carry, carry to bit 7.
// - Working-register rotate forms give same value, memory byte left alone.
// - Subtract-with-borrow removes operand and inverted carry, updates six flags.
// - Carry is 0 for a negative result, 1 otherwise.
// - Immediate subtract-with-borrow uses the literal, result to working register.
// - Subtract-with-borrow to memory writes the difference to the data byte.
// - Decrement-skip writes byte minus one, skips on zero, no flags.
// - Increment-skip writes byte plus one, skips on zero, no flags.
// - Register forms of decrement/increment-skip write working register, skip on zero.
// - Every skip instruction takes two cycles with a dummy slot.
// - Set byte writes all ones; set bit forces one bit; no flags.
// - Bit-test skip skips when the selected bit is not zero.
// - Byte-test skip rewrites the byte and skips when nonzero.
// - Plain subtract computes working register minus byte without carry.
// - Plain subtract writes working register and updates six flags.
`default_nettype none
`include "rss_regs.svh"

module rss_exec_unit
  import rss_pkg::*;
(
  input  wire logic                   clk_in,                  // System clock, 25 MHz
  input  wire logic                   reset_in,                // Asynchronous reset, active high
  input  wire rss_pkg::rss_instr_type instr_in,                // Decoded instruction with operands
  input  wire logic                   irq_pending_in,          // Interrupt request waiting
  output logic                        ready_out,               // Unit accepts an instruction
  output logic [`RSS_PC_W-1:0]        pc_out,                  // Program counter
  output logic [`RSS_DATA_W-1:0]      working_register_out,    // Working register
  output rss_pkg::rss_flags_type      flags_out,               // Status flags
  output logic                        master_irq_gate_out,     // Master interrupt enable
  output logic                        mem_wr_out,              // Data byte write strobe
  output logic [`RSS_DATA_W-1:0]      mem_wr_data_out,         // Data byte to write
  output logic                        skip_taken_out,          // Pulses for one cycle after a skip test passes
  output logic                        irq_serviced_out         // Pending interrupt entered
);

  import rss_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rss_state_type           state;
  rss_state_type           next_state;
  logic [`RSS_PC_W-1:0]    pc;
  logic [`RSS_PC_W-1:0]    next_pc;
  logic [`RSS_DATA_W-1:0]  acc;
  logic [`RSS_DATA_W-1:0]  next_acc;
  rss_flags_type           flags;
  rss_flags_type           next_flags;
  logic                    gate;
  logic                    next_gate;
  logic                    next_mem_wr;
  logic [`RSS_DATA_W-1:0]  next_mem_data;
  logic                    next_skip;
  logic                    next_irq;
  logic                    push;
  logic                    pop;
  logic [`RSS_PC_W-1:0]    stack_top;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic                   issue = (state == RSS_EXEC) & ready_out & instr_in.valid;
  wire rss_op_type             op    = instr_in.op;
  wire logic [`RSS_DATA_W-1:0] m     = instr_in.mem_data;
  wire logic                   c     = flags.carry_flag;

  wire logic [`RSS_DATA_W-1:0] rot_l  = {m[6:0], m[7]};
  wire logic [`RSS_DATA_W-1:0] rot_r  = {m[0], m[7:1]};
  wire logic [`RSS_DATA_W-1:0] rot_lc = {m[6:0], c};
  wire logic [`RSS_DATA_W-1:0] rot_rc = {c, m[7:1]};

  wire logic [`RSS_DATA_W-1:0] dec_val = m - `RSS_ONE;
  wire logic [`RSS_DATA_W-1:0] inc_val = m + `RSS_ONE;
  wire logic [`RSS_DATA_W-1:0] bit_mask = `RSS_ONE << instr_in.bit_sel;

  wire logic is_sub_imm = (op == RSS_SUBTRACT_WITH_BORROW_IMM);
  wire logic is_plain_sub = (op == RSS_SUB_MEM);

  wire logic [`RSS_DATA_W-1:0] sub_operand = is_sub_imm ? instr_in.imm : m;

  logic [`RSS_DATA_W-1:0] sub_diff;
  rss_flags_type          sub_flags;

  // borrow form; plain form has no carry term
  rss_sub_unit u_sub (
    .minuend_in    (acc),
    .subtrahend_in (sub_operand),
    .flags_in      (flags),
    .use_borrow_in (~is_plain_sub),
    .diff_out      (sub_diff),
    .flags_out     (sub_flags)
  );

  rss_stack u_stack (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .push_in  (push),
    .pop_in   (pop),
    .data_in  (pc + `RSS_PC_STEP),
    .top_out  (stack_top)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // flags hold unless an operation names them
    next_flags    = flags;
    next_acc      = acc;
    next_pc       = pc;
    next_gate     = gate;
    next_mem_wr   = 1'b0;
    next_mem_data = m;
    next_skip     = 1'b0;
    next_irq      = 1'b0;
    next_state    = RSS_EXEC;
    push          = 1'b0;
    pop           = 1'b0;
    if (issue) begin
      next_pc = pc + `RSS_PC_STEP;
      unique case (op)
        RSS_NOP: begin
        end
        RSS_OR_TO_MEMORY: begin
          next_mem_wr   = 1'b1;
          next_mem_data = acc | m;
          next_flags.zero_flag = ((acc | m) == `RSS_BYTE_ZERO);
        end
        RSS_RET, RSS_RET_LOAD, RSS_IRQ_RETURN: begin
          // resume at popped address, flags untouched
          next_pc    = stack_top;
          pop        = 1'b1;
          next_state = RSS_SLOT;
          if (op == RSS_RET_LOAD) begin
            next_acc = instr_in.imm;
          end
          if (op == RSS_IRQ_RETURN) begin
            next_gate = 1'b1;
            if (irq_pending_in) begin
              // enter pending service; popped address stays on the stack
              pop       = 1'b0;
              next_pc   = `RSS_IRQ_VECTOR;
              next_gate = 1'b0;
              next_irq  = 1'b1;
            end
          end
        end
        RSS_CALL: begin
          push       = 1'b1;
          next_pc    = instr_in.target;
          next_state = RSS_SLOT;
        end
        RSS_ROT_LEFT: begin
          next_mem_wr   = 1'b1;
          next_mem_data = rot_l;
        end
        RSS_ROT_RIGHT: begin
          next_mem_wr   = 1'b1;
          next_mem_data = rot_r;
        end
        RSS_ROTATE_LEFT_THRU_BORROW_BIT: begin
          next_mem_wr   = 1'b1;
          next_mem_data = rot_lc;
          next_flags.carry_flag = m[7];
        end
        RSS_ROTATE_RIGHT_THRU_BORROW_BIT: begin
          next_mem_wr   = 1'b1;
          next_mem_data = rot_rc;
          next_flags.carry_flag = m[0];
        end
        // register forms reuse the rotated values, memory untouched
        RSS_ROT_LEFT_A: begin
          next_acc = rot_l;
        end
        RSS_ROT_RIGHT_A: begin
          next_acc = rot_r;
        end
        RSS_ROTATE_LEFT_THRU_BORROW_BIT_A: begin
          next_acc = rot_lc;
          next_flags.carry_flag = m[7];
        end
        RSS_ROTATE_RIGHT_THRU_BORROW_BIT_A: begin
          next_acc = rot_rc;
          next_flags.carry_flag = m[0];
        end
        // borrow, immediate and plain subtracts to register with six flags
        RSS_SUBTRACT_WITH_BORROW, RSS_SUBTRACT_WITH_BORROW_IMM, RSS_SUB_MEM: begin
          next_acc   = sub_diff;
          next_flags = sub_flags;
        end
        RSS_SUBTRACT_WITH_BORROW_TO_MEM: begin
          next_mem_wr   = 1'b1;
          next_mem_data = sub_diff;
          next_flags    = sub_flags;
        end
        RSS_DECREMENT_SKIP_IF_NULL: begin
          next_mem_wr   = 1'b1;
          next_mem_data = dec_val;
          next_skip     = (dec_val == `RSS_BYTE_ZERO);
          next_state    = RSS_SLOT;
        end
        RSS_INCREMENT_SKIP_IF_NULL: begin
          next_mem_wr   = 1'b1;
          next_mem_data = inc_val;
          next_skip     = (inc_val == `RSS_BYTE_ZERO);
          next_state    = RSS_SLOT;
        end
        RSS_DECREMENT_SKIP_IF_NULL_A: begin
          next_acc   = dec_val;
          next_skip  = (dec_val == `RSS_BYTE_ZERO);
          next_state = RSS_SLOT;
        end
        RSS_INCREMENT_SKIP_IF_NULL_A: begin
          next_acc   = inc_val;
          next_skip  = (inc_val == `RSS_BYTE_ZERO);
          next_state = RSS_SLOT;
        end
        RSS_SET_BYTE: begin
          next_mem_wr   = 1'b1;
          next_mem_data = `RSS_BYTE_ONES;
        end
        RSS_SET_BIT: begin
          next_mem_wr   = 1'b1;
          next_mem_data = m | bit_mask;
        end
        RSS_SKIP_IF_BIT_NONNULL: begin
          next_skip  = ((m & bit_mask) != `RSS_BYTE_ZERO);
          next_state = RSS_SLOT;
        end
        RSS_SKIP_IF_NONNULL: begin
          next_mem_wr   = 1'b1;
          next_mem_data = m;
          next_skip     = (m != `RSS_BYTE_ZERO);
          next_state    = RSS_SLOT;
        end
        default: begin
        end
      endcase
      if (next_skip) begin
        next_pc = pc + `RSS_PC_SKIP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // dummy slot holds issue off for one cycle after a skip
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state     <= RSS_EXEC;
      ready_out <= 1'b0;
    end else begin
      state     <= next_state;
      ready_out <= (next_state == RSS_EXEC);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc    <= `RSS_PC_RESET;
      acc   <= `RSS_ACC_RESET;
      flags <= '0;
      gate  <= 1'b0;
    end else begin
      pc    <= next_pc;
      acc   <= next_acc;
      flags <= next_flags;
      gate  <= next_gate;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_wr_out       <= 1'b0;
      mem_wr_data_out  <= `RSS_BYTE_ZERO;
      skip_taken_out   <= 1'b0;
      irq_serviced_out <= 1'b0;
    end else begin
      mem_wr_out       <= next_mem_wr;
      mem_wr_data_out  <= next_mem_data;
      skip_taken_out   <= next_skip;
      irq_serviced_out <= next_irq;
    end
  end

  assign pc_out               = pc;
  assign working_register_out = acc;
  assign flags_out            = flags;
  assign master_irq_gate_out  = gate;

endmodule : rss_exec_unit

`default_nettype wire

// >>> tb/rss_exec_props.sv
// Checker for the rotate, skip and subtract execution unit
`default_nettype none
`include "rss_regs.svh"

module rss_exec_props (
  input wire logic                   clk_in,               // Clock
  input wire logic                   reset_in,             // Reset
  input wire rss_pkg::rss_instr_type instr_in,             // Instruction
  input wire logic                   irq_pending_in,       // Pending interrupt
  input wire logic                   ready_out,            // Accepting
  input wire logic [`RSS_PC_W-1:0]   pc_out,               // Program counter
  input wire logic [`RSS_DATA_W-1:0] working_register_out, // Working register
  input wire rss_pkg::rss_flags_type flags_out,            // Flags
  input wire logic                   master_irq_gate_out,  // Interrupt gate
  input wire logic                   mem_wr_out,           // Write strobe
  input wire logic [`RSS_DATA_W-1:0] mem_wr_data_out,      // Write data
  input wire logic                   skip_taken_out,       // Skip pulse
  input wire logic                   irq_serviced_out      // Interrupt entered
);
  timeunit 1ns;
  timeprecision 1ns;
  import rss_pkg::*;

  logic       take;
  logic       skip_op;
  rss_op_type op;
  logic [7:0] m;
  logic [7:0] dec_v;
  logic [8:0] rlc9;
  logic [8:0] rrc9;
  assign take = ready_out && instr_in.valid;
  assign op = instr_in.op;
  assign m = instr_in.mem_data;
  assign dec_v = m - `RSS_ONE;
  // Expected {result, carry} of the through-carry rotates
  assign rlc9 = {m[6:0], flags_out.carry_flag, m[7]};
  assign rrc9 = {flags_out.carry_flag, m[7:1], m[0]};
  assign skip_op = op inside {RSS_DECREMENT_SKIP_IF_NULL, RSS_DECREMENT_SKIP_IF_NULL_A, RSS_INCREMENT_SKIP_IF_NULL,
                              RSS_INCREMENT_SKIP_IF_NULL_A, RSS_SKIP_IF_BIT_NONNULL, RSS_SKIP_IF_NONNULL};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_or_mem;
    take && op == RSS_OR_TO_MEMORY |=> mem_wr_out && mem_wr_data_out == ($past(working_register_out) | $past(m));
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or to memory result wrong");
  property p_ret;
    take && op == RSS_RET |=> !ready_out && flags_out == $past(flags_out);
  endproperty
  a_ret: assert property (p_ret) else $error("return disturbed flags or slot");
  property p_irq_return;
    take && op == RSS_IRQ_RETURN && !irq_pending_in |=> master_irq_gate_out && !irq_serviced_out;
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("interrupt return left gate closed");
  property p_irq_return_irq;
    take && op == RSS_IRQ_RETURN && irq_pending_in |=> irq_serviced_out && pc_out == `RSS_IRQ_VECTOR;
  endproperty
  a_irq_return_irq: assert property (p_irq_return_irq) else $error("pending interrupt not entered");
  property p_rot_left;
    take && op == RSS_ROT_LEFT |=> mem_wr_out && mem_wr_data_out == {$past(m[6:0]), $past(m[7])};
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");
  property p_rlc_acc;
    take && op == RSS_ROTATE_LEFT_THRU_BORROW_BIT_A |=>
      !mem_wr_out && {working_register_out, flags_out.carry_flag} == $past(rlc9);
  endproperty
  a_rlc_acc: assert property (p_rlc_acc) else $error("rotate left through carry wrong");
  property p_rrc_mem;
    take && op == RSS_ROTATE_RIGHT_THRU_BORROW_BIT |=>
      mem_wr_out && {mem_wr_data_out, flags_out.carry_flag} == $past(rrc9);
  endproperty
  a_rrc_mem: assert property (p_rrc_mem) else $error("rotate right through carry wrong");
  property p_dec_skip;
    take && op == RSS_DECREMENT_SKIP_IF_NULL |=>
      mem_wr_out && mem_wr_data_out == $past(dec_v) && skip_taken_out == ($past(dec_v) == 8'h00);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");
  property p_skip_slot;
    take && skip_op |=> !ready_out ##1 ready_out;
  endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("skip not two cycles");
  property p_skip_pc;
    take && skip_op |=> pc_out == $past(pc_out) + (skip_taken_out ? `RSS_PC_SKIP : `RSS_PC_STEP);
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skipped instruction not passed over");
endmodule // rss_exec_props

`default_nettype wire

// >>> tb/rss_exec_unit_tb_top.sv
// Self-checking bench for the rotate, skip and subtract execution unit
`default_nettype none
`include "rss_regs.svh"

module rss_exec_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rss_pkg::*;

  logic                   clk_in = 1'h0;
  logic                   reset_in = 1'h1;
  rss_instr_type          instr_in = '0;
  logic                   irq_pending_in = 1'h0;
  logic                   ready_out;
  logic [`RSS_PC_W-1:0]   pc_out;
  logic [`RSS_DATA_W-1:0] working_register_out;
  rss_flags_type          flags_out;
  logic                   master_irq_gate_out;
  logic                   mem_wr_out;
  logic [`RSS_DATA_W-1:0] mem_wr_data_out;
  logic                   skip_taken_out;
  logic                   irq_serviced_out;
  int                     fails = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  logic                   pend = 1'h0;
  logic [13:0]            ep;
  logic [13:0]            ret_pc;
  logic [13:0]            res;
  logic [7:0]             ea;
  logic [7:0]             r;
  logic [7:0]             m;
  rss_flags_type          ef;

  rss_exec_unit u_rss_exec_unit (
    .clk_in,
    .reset_in,
    .instr_in,
    .irq_pending_in,
    .ready_out,
    .pc_out,
    .working_register_out,
    .flags_out,
    .master_irq_gate_out,
    .mem_wr_out,
    .mem_wr_data_out,
    .skip_taken_out,
    .irq_serviced_out
  );

  always #20 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hung handshake ends the run here rather than stalling forever
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held from one edge to the taking edge, results read mid-cycle
  task automatic run(input rss_op_type op, input logic [7:0] md, input logic [7:0] imm, input logic [2:0] b);
    int n;
    n = 0;
    while (ready_out !== 1'h1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    instr_in <= '{1'h1, op, md, imm, b, 14'h0123};
    irq_pending_in <= pend;
    @(posedge clk_in);
    instr_in.valid <= 1'h0;
    irq_pending_in <= 1'h0;
    @(negedge clk_in);
  endtask

  task automatic expect_all(input logic wr, input logic [7:0] d, input logic s);
    chk(16'(mem_wr_out), 16'(wr));
    if (wr) chk(16'(mem_wr_data_out), 16'(d));
    chk(16'(skip_taken_out), 16'(s));
    chk(16'(pc_out), 16'(ep));
    chk(16'(working_register_out), 16'(ea));
    chk(16'(flags_out), 16'(ef));
  endtask

  task automatic rst(input int n);
    @(posedge clk_in);
    reset_in <= 1'h1;
    repeat (n) @(posedge clk_in);
    reset_in <= 1'h0;
    @(negedge clk_in);
    ep = '0;
    ea = '0;
    ef = '0;
    expect_all(1'h0, 8'h00, 1'h0);
    chk(16'(master_irq_gate_out), 16'h0000);
  endtask

  task automatic call_to();
    ret_pc = ep + 14'h0001;
    ep = 14'h0123;
    run(RSS_CALL, 8'h00, 8'h00, 3'h0);
    expect_all(1'h0, 8'h00, 1'h0);
  endtask

  task automatic set_acc(input logic [7:0] v);
    call_to();
    ep = ret_pc;
    ea = v;
    run(RSS_RET_LOAD, 8'h00, v, 3'h0);
    expect_all(1'h0, 8'h00, 1'h0);
  endtask

  task automatic set_c(input logic c);
    ea = {7'h00, ef.carry_flag};
    ef.carry_flag = c;
    ep = ep + 14'h0001;
    run(RSS_ROTATE_LEFT_THRU_BORROW_BIT_A, {c, 7'h00}, 8'h00, 3'h0);
    expect_all(1'h0, 8'h00, 1'h0);
  endtask

  // Returns {carry, zero, half, wrap, signed borrow, chained null, difference}
  function automatic logic [13:0] sub_f(input logic [7:0] a, input logic [7:0] b, input logic c,
                                        input logic cz, input logic brw);
    logic [8:0] d;
    logic [4:0] h;
    logic       v;
    d = {1'h0, a} - {1'h0, b} - {8'h00, brw & ~c};
    h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, brw & ~c};
    v = (a[7] ^ b[7]) & (a[7] ^ d[7]);
    return {~d[8], d[7:0] == 8'h00, ~h[4], v, v ^ d[7], (d[7:0] == 8'h00) & (cz | ~brw), d[7:0]};
  endfunction

  task automatic sb(input rss_op_type op, input logic [7:0] a, input logic [7:0] b, input logic c);
    set_c(c);
    set_acc(a);
    res = sub_f(a, b, c, ef.chained_null_flag, op != RSS_SUB_MEM);
    ef = rss_flags_type'(res[13:8]);
    if (op != RSS_SUBTRACT_WITH_BORROW_TO_MEM) ea = res[7:0];
    ep = ep + 14'h0001;
    if (op == RSS_SUBTRACT_WITH_BORROW_IMM) run(op, ~b, b, 3'h0);
    else run(op, b, ~b, 3'h0);
    expect_all(op == RSS_SUBTRACT_WITH_BORROW_TO_MEM, res[7:0], 1'h0);
  endtask

  task automatic sk(input rss_op_type op, input logic [7:0] md, input logic [2:0] b,
                    input logic wr, input logic [7:0] d, input logic s);
    if (!wr && op != RSS_SKIP_IF_BIT_NONNULL) ea = d;
    ep = ep + (s ? 14'h0002 : 14'h0001);
    run(op, md, 8'h00, b);
    expect_all(wr, d, s);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst(16);
    for (int i = 0; i < 8; i++) begin
      m = 8'h96 ^ {8{i[0]}};
      case (i / 2)
        0: r = {m[6:0], m[7]};
        1: r = {m[0], m[7:1]};
        2: r = {m[6:0], ef.carry_flag};
        default: r = {ef.carry_flag, m[7:1]};
      endcase
      if (i >= 4) ef.carry_flag = (i < 6) ? m[7] : m[0];
      if (i[0]) ea = r;
      ep = ep + 14'h0001;
      run(rss_op_type'(5'(int'(RSS_ROT_LEFT) + i)), m, 8'h00, 3'h0);
      expect_all(!i[0], r, 1'h0);
    end
    set_acc(8'h0F);
    ef.zero_flag = 1'h0;
    ep = ep + 14'h0001;
    run(RSS_OR_TO_MEMORY, 8'h30, 8'h00, 3'h0);
    expect_all(1'h1, 8'h3F, 1'h0);
    sb(RSS_SUBTRACT_WITH_BORROW, 8'h05, 8'h03, 1'h1);
    sb(RSS_SUBTRACT_WITH_BORROW_IMM, 8'h05, 8'h03, 1'h0);
    sb(RSS_SUBTRACT_WITH_BORROW_TO_MEM, 8'h03, 8'h05, 1'h1);
    sb(RSS_SUB_MEM, 8'h80, 8'h01, 1'h0);
    sb(RSS_SUBTRACT_WITH_BORROW, 8'h10, 8'h01, 1'h0);
    sb(RSS_SUBTRACT_WITH_BORROW, 8'h01, 8'h00, 1'h0);
    sb(RSS_SUB_MEM, 8'h00, 8'h00, 1'h0);
    sb(RSS_SUBTRACT_WITH_BORROW_TO_MEM, 8'h01, 8'h01, 1'h1);
    sk(RSS_INCREMENT_SKIP_IF_NULL, 8'hFF, 3'h0, 1'h1, 8'h00, 1'h1);
    sk(RSS_INCREMENT_SKIP_IF_NULL, 8'h05, 3'h0, 1'h1, 8'h06, 1'h0);
    sk(RSS_DECREMENT_SKIP_IF_NULL, 8'h01, 3'h0, 1'h1, 8'h00, 1'h1);
    sk(RSS_DECREMENT_SKIP_IF_NULL, 8'h00, 3'h0, 1'h1, 8'hFF, 1'h0);
    sk(RSS_DECREMENT_SKIP_IF_NULL_A, 8'h03, 3'h0, 1'h0, 8'h02, 1'h0);
    sk(RSS_INCREMENT_SKIP_IF_NULL_A, 8'hFF, 3'h0, 1'h0, 8'h00, 1'h1);
    sk(RSS_NOP, 8'h00, 3'h0, 1'h0, 8'h00, 1'h0);
    sk(RSS_SET_BYTE, 8'h12, 3'h0, 1'h1, 8'hFF, 1'h0);
    sk(RSS_SET_BIT, 8'h41, 3'h5, 1'h1, 8'h61, 1'h0);
    sk(RSS_SKIP_IF_BIT_NONNULL, 8'h08, 3'h3, 1'h0, 8'h00, 1'h1);
    sk(RSS_SKIP_IF_BIT_NONNULL, 8'hF7, 3'h3, 1'h0, 8'h00, 1'h0);
    sk(RSS_SKIP_IF_NONNULL, 8'h00, 3'h0, 1'h1, 8'h00, 1'h0);
    sk(RSS_SKIP_IF_NONNULL, 8'h5A, 3'h0, 1'h1, 8'h5A, 1'h1);
    call_to();
    ep = ret_pc;
    run(RSS_RET, 8'h00, 8'h00, 3'h0);
    expect_all(1'h0, 8'h00, 1'h0);
    call_to();
    ep = ret_pc;
    run(RSS_IRQ_RETURN, 8'h00, 8'h00, 3'h0);
    chk(16'(master_irq_gate_out), 16'h0001);
    expect_all(1'h0, 8'h00, 1'h0);
    call_to();
    pend = 1'h1;
    ep = `RSS_IRQ_VECTOR;
    run(RSS_IRQ_RETURN, 8'h00, 8'h00, 3'h0);
    pend = 1'h0;
    chk(16'(irq_serviced_out), 16'h0001);
    expect_all(1'h0, 8'h00, 1'h0);
    ep = ret_pc;
    run(RSS_RET, 8'h00, 8'h00, 3'h0);
    expect_all(1'h0, 8'h00, 1'h0);
    rst(3);
    give_verdict();
  end
endmodule // rss_exec_unit_tb_top

bind rss_exec_unit rss_exec_props u_rss_exec_props (
  .clk_in,
  .reset_in,
  .instr_in,
  .irq_pending_in,
  .ready_out,
  .pc_out,
  .working_register_out,
  .flags_out,
  .master_irq_gate_out,
  .mem_wr_out,
  .mem_wr_data_out,
  .skip_taken_out,
  .irq_serviced_out
);

`default_nettype wire
